// >>> rtl/io_ports.sv
// Four 8-bit parallel I/O ports with mode registers and first-port
// strobe handshake, reached through the core's register file port.
// Assumes the core issues one-cycle read and write strobes with an
// 8-bit register address and the current expanded register bank.
// What this block does
// - Thirty-two I/O lines as four 8-bit ports, each its own register.
// - First port per nibble, second per byte, third per bit.
// - Push-pull outputs; first three ports can drop to open-drain.
// - Mode registers at F8h (ports 0/1), F7h (port 3), F6h (port 2).
// - Mode registers writable anytime; function changes at once.
// - Ports and modes act like ordinary registers for any instruction.
// - Each bit of first three ports keeps separate in and out storage.
// - Writing an input bit stores output value, unseen while input.
// - Switching to output drives the stored value, then readable.
// - Pins settle through two clock periods before any read.
// - First port data at 00h, bank 0 only; writes hit output register.
// - Reading an output nibble returns pin levels.
// - Reading input returns pins, or strobe-latched value under handshake.
// - Lower nibble: config bits 1,0 = 01 input, 00 output.
// - Upper nibble: config bits 7,6 = 01 input, 00 output.
// - First port may instead drive external memory address.
// - First port nibbles globally push-pull or open-drain.
// - Function bit 2 set puts first port under strobe handshake.
// - Line 2 and line 5 of fourth port carry valid and ready.
// - Upper nibble sets direction; lower joins only when matching.
`timescale 1ns/1ps
`include "io_ports_regs.svh"
module io_ports (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [3:0] expanded_register_bank,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out,
  output logic [7:0] port_zero_oe,
  input wire logic [7:0] port_one_in,
  output logic [7:0] port_one_out,
  output logic [7:0] port_one_oe,
  input wire logic [7:0] port_two_in,
  output logic [7:0] port_two_out,
  output logic [7:0] port_two_oe,
  input wire logic [3:0] port_three_in,
  output logic [7:0] port_three_out,
  output logic [7:0] port_three_oe,
  input wire logic [7:0] mem_addr_out,
  input wire logic [7:0] mem_ad_out,
  input wire logic mem_ad_oe,
  output logic [7:0] mem_ad_in
);
  import io_ports_pkg::*;

  // ====================================================================
  // Helpers
  function automatic logic nib_out(input logic [1:0] m);
    return nib_mode_t'(m) == NIB_OUTPUT;
  endfunction

  function automatic logic nib_in(input logic [1:0] m);
    return nib_mode_t'(m) == NIB_INPUT;
  endfunction

  function automatic logic nib_addr(input logic [1:0] m);
    return nib_mode_t'(m) inside {NIB_ADDR, NIB_ADDR_ALT};
  endfunction

  function automatic logic [7:0] drive_en(input logic [7:0] out_en,
      input logic od, input logic [7:0] val);
    // Open-drain only pulls low; a high bit releases the line
    return od ? (out_en & ~val) : out_en;
  endfunction

  // ====================================================================
  // Synchronised pins
  // A read sees pins from two edges back: latency traded for safety
  logic [7:0] zero_s;
  logic [7:0] one_s;
  logic [7:0] two_s;
  logic [3:0] three_s;

  pin_sync #(.WIDTH(8)) u_sync_zero (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(port_zero_in),
    .sync_out(zero_s)
  );
  pin_sync #(.WIDTH(8)) u_sync_one (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(port_one_in),
    .sync_out(one_s)
  );
  pin_sync #(.WIDTH(8)) u_sync_two (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(port_two_in),
    .sync_out(two_s)
  );
  pin_sync #(.WIDTH(4)) u_sync_three (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(port_three_in),
    .sync_out(three_s)
  );

  // ====================================================================
  // Register state
  // Modes reset to all-input so only fourth-port lines 7..4 drive before software sets up
  logic [7:0] zero_out_q, zero_out_d;
  logic [7:0] one_out_q, one_out_d;
  logic [7:0] two_out_q, two_out_d;
  logic [7:0] three_out_q, three_out_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] two_dir_q, two_dir_d;
  logic [7:0] func_q, func_d;
  logic [7:0] zero_in_q, zero_in_d;
  logic [7:0] rdata_q, rdata_d;

  // ====================================================================
  // Address decode
  logic bank_ok;
  logic wr_zero, wr_one, wr_two, wr_three;
  logic wr_cfg, wr_dir, wr_func;
  logic rd_zero;

  // Mode registers answer in every bank; only port data is banked
  assign bank_ok = expanded_register_bank == `PORT_DATA_BANK;
  assign wr_zero = reg_wr && bank_ok
                   && reg_addr == `PORT_ZERO_DATA_OFS;
  assign wr_one = reg_wr && bank_ok && reg_addr == `PORT_ONE_DATA_OFS;
  assign wr_two = reg_wr && bank_ok && reg_addr == `PORT_TWO_DATA_OFS;
  assign wr_three = reg_wr && bank_ok
                    && reg_addr == `PORT_THREE_DATA_OFS;
  assign wr_cfg = reg_wr && reg_addr == `PORT_ZERO_ONE_CONFIG_OFS;
  assign wr_dir = reg_wr && reg_addr == `PORT_TWO_DIRECTION_OFS;
  assign wr_func = reg_wr && reg_addr == `PORT_THREE_FUNCTION_OFS;
  assign rd_zero = reg_rd && bank_ok && reg_addr == `PORT_ZERO_DATA_OFS;

  // ====================================================================
  // Mode decode, live from the mode registers
  logic [1:0] lo_mode, hi_mode, one_mode;
  logic lo_is_out, hi_is_out, lo_is_in, hi_is_in;
  logic one_is_out;
  logic hs_en, hs_dir_in, lo_joins;
  logic [7:0] hs_mask;
  logic hs_line_b, hs_capture;

  assign lo_mode = cfg_q[`CFG_LOW_NIB_LSB +: 2];
  assign hi_mode = cfg_q[`CFG_HIGH_NIB_LSB +: 2];
  assign one_mode = cfg_q[`CFG_ONE_MODE_LSB +: 2];
  assign lo_is_out = nib_out(lo_mode);
  assign lo_is_in = nib_in(lo_mode);
  assign hi_is_out = nib_out(hi_mode);
  assign hi_is_in = nib_in(hi_mode);
  assign one_is_out = nib_out(one_mode);

  // Handshake only while the upper nibble is ordinary I/O
  assign hs_en = func_q[`FUNC_HANDSHAKE_BIT]
                 && (hi_is_in || hi_is_out);
  assign hs_dir_in = hi_is_in;
  // Lower nibble joins only with the same direction; address never joins
  assign lo_joins = (lo_is_in && hi_is_in)
                    || (lo_is_out && hi_is_out);
  assign hs_mask = {4'hf, lo_joins ? 4'hf : 4'h0};

  // Port zero reads and writes pace the handshake
  strobe_handshake u_handshake (
    .clock(clock),
    .rst_n(rst_n),
    .enable(hs_en),
    .dir_input(hs_dir_in),
    .line_a(three_s[`HS_LINE_A]),
    .port_read(rd_zero),
    .port_write(wr_zero),
    .line_b(hs_line_b),
    .capture(hs_capture)
  );

  // ====================================================================
  // Register updates
  always_comb begin
    // Writes land whatever the direction, so a value can be preset
    zero_out_d = wr_zero ? reg_wdata : zero_out_q;
    one_out_d = wr_one ? reg_wdata : one_out_q;
    two_out_d = wr_two ? reg_wdata : two_out_q;
    three_out_d = wr_three ? reg_wdata : three_out_q;
    cfg_d = wr_cfg ? reg_wdata : cfg_q;
    two_dir_d = wr_dir ? reg_wdata : two_dir_q;
    func_d = wr_func ? reg_wdata : func_q;
    // Separate input register, loaded by the input strobe
    // Held until the next strobe, so a late read still sees the byte
    zero_in_d = hs_capture ? zero_s : zero_in_q;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zero_out_q <= `PORT_OUT_RST;
      one_out_q <= `PORT_OUT_RST;
      two_out_q <= `PORT_OUT_RST;
      three_out_q <= `PORT_THREE_OUT_RST;
      cfg_q <= `PORT_ZERO_ONE_CONFIG_RST;
      two_dir_q <= `PORT_TWO_DIRECTION_RST;
      func_q <= `PORT_THREE_FUNCTION_RST;
      zero_in_q <= `PORT_OUT_RST;
      rdata_q <= 8'h00;
    end else begin
      zero_out_q <= zero_out_d;
      one_out_q <= one_out_d;
      two_out_q <= two_out_d;
      three_out_q <= three_out_d;
      cfg_q <= cfg_d;
      two_dir_q <= two_dir_d;
      func_q <= func_d;
      zero_in_q <= zero_in_d;
      rdata_q <= rdata_d;
    end
  end

  // ====================================================================
  // Read path
  logic [7:0] zero_view;
  logic [7:0] latched_sel;
  logic [7:0] three_view;

  // Inputs under handshake read the strobe latch, all else the pins
  assign latched_sel = (hs_en && hs_dir_in) ? hs_mask : 8'h00;
  assign zero_view = (latched_sel & zero_in_q)
                     | (~latched_sel & zero_s);

  // Port three has one output register and one input register in total
  assign three_view = {three_out_q[7:4], three_s};

  // Registered read data: one settled byte per read, held until the next

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = 8'h00;
      if (reg_addr == `PORT_ZERO_ONE_CONFIG_OFS) begin
        rdata_d = cfg_q;
      end else if (reg_addr == `PORT_TWO_DIRECTION_OFS) begin
        rdata_d = two_dir_q;
      end else if (reg_addr == `PORT_THREE_FUNCTION_OFS) begin
        rdata_d = func_q;
      end else if (bank_ok) begin
        unique case (reg_addr)
          `PORT_ZERO_DATA_OFS: rdata_d = zero_view;
          `PORT_ONE_DATA_OFS: rdata_d = one_s;
          `PORT_TWO_DATA_OFS: rdata_d = two_s;
          `PORT_THREE_DATA_OFS: rdata_d = three_view;
          default: rdata_d = 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;

  // ====================================================================
  // Pin drive
  logic [7:0] zero_oe_raw;
  logic [7:0] zero_val;
  logic one_addr;

  // Address nibbles follow the memory interface, others the out register
  assign zero_val = {nib_addr(hi_mode) ? mem_addr_out[7:4]
                                       : zero_out_q[7:4],
                     nib_addr(lo_mode) ? mem_addr_out[3:0]
                                       : zero_out_q[3:0]};
  assign zero_oe_raw = {{4{!hi_is_in}}, {4{!lo_is_in}}};
  assign port_zero_out = zero_val;
  assign port_zero_oe = drive_en(zero_oe_raw, cfg_q[`CFG_ZERO_OD_BIT],
                                 zero_val);

  // Second port: whole byte, or multiplexed address/data bus
  // In address/data mode the memory interface owns the lines
  assign one_addr = one_mode[1];
  assign port_one_out = one_addr ? mem_ad_out : one_out_q;
  assign port_one_oe = one_addr ? {8{mem_ad_oe}}
                       : drive_en({8{one_is_out}},
                                  cfg_q[`CFG_ONE_OD_BIT],
                                  one_out_q);
  assign mem_ad_in = one_s;

  // Third port: one direction bit per line, 1 means input
  assign port_two_out = two_out_q;
  assign port_two_oe = drive_en(~two_dir_q, func_q[`FUNC_TWO_OD_BIT],
                                two_out_q);

  // Fourth port: lines 3..0 inputs, 7..4 outputs; line 5 may be taken
  always_comb begin
    port_three_out = three_out_q;
    if (func_q[`FUNC_HANDSHAKE_BIT]) begin
      port_three_out[`HS_LINE_B] = hs_line_b;
    end
  end
  // Lines 7..4 always drive; lines 3..0 are inputs only
  assign port_three_oe = 8'hf0;
endmodule // io_ports

// >>> rtl/io_ports_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the four-port I/O block. Included by the design and the checker.
`ifndef IO_PORTS_REGS_SVH
`define IO_PORTS_REGS_SVH

// Register file offsets
`define PORT_ZERO_DATA_OFS 8'h00
`define PORT_ONE_DATA_OFS 8'h01
`define PORT_TWO_DATA_OFS 8'h02
`define PORT_THREE_DATA_OFS 8'h03
`define PORT_TWO_DIRECTION_OFS 8'hf6
`define PORT_THREE_FUNCTION_OFS 8'hf7
`define PORT_ZERO_ONE_CONFIG_OFS 8'hf8

// Bank in which the port data registers are visible
`define PORT_DATA_BANK 4'h0

// port_zero_one_config fields
`define CFG_LOW_NIB_LSB 0
`define CFG_ZERO_OD_BIT 2
`define CFG_ONE_MODE_LSB 3
`define CFG_ONE_OD_BIT 5
`define CFG_HIGH_NIB_LSB 6

// port_three_function fields
`define FUNC_TWO_OD_BIT 0
`define FUNC_HANDSHAKE_BIT 2

// port_three line numbers used by the handshake
`define HS_LINE_A 2
`define HS_LINE_B 5

// Reset values
`define PORT_ZERO_ONE_CONFIG_RST 8'h49
`define PORT_TWO_DIRECTION_RST 8'hff
`define PORT_THREE_FUNCTION_RST 8'h00
`define PORT_OUT_RST 8'h00
`define PORT_THREE_OUT_RST 8'hf0

// Synchroniser depth in clock periods
`define PIN_SYNC_STAGES 2

`endif

// >>> rtl/io_ports_pkg.sv
// Types shared by the I/O port block and its handshake engine.
// Assumes the constants header is included where numbers are needed.
package io_ports_pkg;

  typedef enum logic [1:0] {
    NIB_OUTPUT = 2'b00,
    NIB_INPUT = 2'b01,
    NIB_ADDR = 2'b10,
    NIB_ADDR_ALT = 2'b11
  } nib_mode_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_HOLD = 2'b01,
    HS_PEND = 2'b10,
    HS_VALID = 2'b11
  } hs_state_t;

endpackage

// >>> rtl/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clock; only stage two is read.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // pin_sync

// >>> rtl/strobe_handshake.sv
// Strobe handshake engine for the first port.
// Assumes line_a is already synchronised and strobes are one-cycle pulses.
`timescale 1ns/1ps
module strobe_handshake (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic dir_input,
  input wire logic line_a,
  input wire logic port_read,
  input wire logic port_write,
  output logic line_b,
  output logic capture
);
  import io_ports_pkg::*;

  hs_state_t state_q;
  hs_state_t state_d;
  logic line_a_q;
  logic line_a_d;
  logic capture_c;

  // ====================================================================
  // Next state
  always_comb begin
    state_d = state_q;
    line_a_d = line_a;
    capture_c = 1'b0;
    if (!enable) begin
      state_d = HS_IDLE;
    end else if (dir_input) begin
      unique case (state_q)
        HS_IDLE: begin
          // Latch on the valid edge, then drop ready
          if (line_a && !line_a_q) begin
            capture_c = 1'b1;
            state_d = HS_HOLD;
          end
        end
        HS_HOLD: begin
          if (port_read) begin
            state_d = HS_IDLE;
          end
        end
        default: state_d = HS_IDLE;
      endcase
    end else begin
      unique case (state_q)
        HS_PEND: begin
          if (line_a) begin
            state_d = HS_VALID;
          end
        end
        HS_VALID: begin
          // Falling ready is the acceptance; a new write restarts
          if (!line_a) begin
            state_d = port_write ? HS_PEND : HS_IDLE;
          end
        end
        default: begin
          if (port_write) begin
            state_d = HS_PEND;
          end
        end
      endcase
    end
  end

  // ====================================================================
  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HS_IDLE;
      line_a_q <= 1'b0;
    end else begin
      state_q <= state_d;
      line_a_q <= line_a_d;
    end
  end

  // Input: ready while idle. Output: valid while presenting.
  assign line_b = dir_input ? (enable && state_q == HS_IDLE)
                            : (state_q == HS_VALID);
  assign capture = capture_c;
endmodule // strobe_handshake

// >>> tb/io_ports_assertions.sv
// Checker for the I/O port block, seeing only its top-level ports.
// Assumes the register constants header is on the include path.
`timescale 1ns/1ps
`include "io_ports_regs.svh"
module io_ports_assertions
  import io_ports_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [3:0] expanded_register_bank,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] port_zero_oe,
  input wire logic [7:0] port_two_out,
  input wire logic [7:0] port_two_oe,
  input wire logic [3:0] port_three_in,
  input wire logic [7:0] port_three_out
);
  // ==========================================================
  // Mirror of the F8h and F7h mode registers
  logic [7:0] cfg_q;
  logic [7:0] fn_q;
  logic [1:0] up_q;
  logic hs_in;
  logic hs_out;
  assign hs_in = fn_q[2] && cfg_q[7:6] == NIB_INPUT;
  assign hs_out = fn_q[2] && cfg_q[7:6] == NIB_OUTPUT;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `PORT_ZERO_ONE_CONFIG_RST;
      fn_q <= `PORT_THREE_FUNCTION_RST;
      up_q <= 2'h0;
    end else begin
      // Sync stages hold reset zeros for a while after release
      if (up_q != 2'h3)
        up_q <= up_q + 2'h1;
      if (reg_wr && reg_addr == 8'hf8)
        cfg_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'hf7)
        fn_q <= reg_wdata;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_p2_wr;
    reg_wr && reg_addr == 8'h02;
  endsequence
  property p_p2_write;
    s_p2_wr ##0 expanded_register_bank == 4'h0
      |=> port_two_out == $past(reg_wdata);
  endproperty
  property p_p2_bank;
    s_p2_wr ##0 expanded_register_bank != 4'h0 |=> $stable(port_two_out);
  endproperty
  property p_p2_dir;
    reg_wr && reg_addr == 8'hf6
      |=> (port_two_oe & $past(reg_wdata)) == 8'h00;
  endproperty
  property p_unmapped;
    reg_rd && reg_addr inside {[8'h04:8'hef]} |=> reg_rdata == 8'h00;
  endproperty
  property p_p3_sync;
    up_q == 2'h3 && reg_rd && reg_addr == 8'h03 &&
      expanded_register_bank == 4'h0
      |=> reg_rdata[3:0] == $past(port_three_in, 3);
  endproperty
  property p_p0_oe;
    !cfg_q[2] && !cfg_q[7] && !cfg_q[1] |-> port_zero_oe ==
      {{4{cfg_q[7:6] == NIB_OUTPUT}}, {4{cfg_q[1:0] == NIB_OUTPUT}}};
  endproperty
  property p_rdy_fall;
    hs_in && port_three_out[5] && $rose(port_three_in[2])
      |-> ##[2:6] !port_three_out[5];
  endproperty
  property p_dav_drop;
    hs_out && port_three_out[5] && $fell(port_three_in[2])
      |-> ##[1:5] !port_three_out[5];
  endproperty
  a_p2_write: assert property (p_p2_write)
    else $error("port two write not stored");
  a_p2_bank: assert property (p_p2_bank)
    else $error("write in wrong bank took effect");
  a_p2_dir: assert property (p_p2_dir)
    else $error("input bit of port two is driven");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_p3_sync: assert property (p_p3_sync)
    else $error("port three read not two-stage synced");
  a_p0_oe: assert property (p_p0_oe)
    else $error("port zero nibble enables wrong");
  a_rdy_fall: assert property (p_rdy_fall)
    else $error("ready did not drop after strobe");
  a_dav_drop: assert property (p_dav_drop)
    else $error("valid did not end after accept");
endmodule // io_ports_assertions

bind io_ports io_ports_assertions i_io_ports_assertions (.clock, .rst_n,
  .reg_addr, .expanded_register_bank, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .port_zero_oe, .port_two_out, .port_two_oe,
  .port_three_in, .port_three_out);

// >>> tb/hs_partner.sv
// Far-side peripheral for the first-port strobe handshake.
// Assumes line_a feeds handshake line a and pins carry port zero levels.
`timescale 1ns/1ps
module hs_partner (
  input wire logic clock,
  input wire logic out_mode,
  input wire logic slow,
  input wire logic line_b,
  input wire logic [7:0] pins,
  output logic line_a,
  output logic [7:0] drive,
  output logic [7:0] rx,
  output logic [7:0] rx_n
);
  // ==========================================================
  // Strobe and ready lines
  logic dav_q = 1'b0;
  logic rdy_q = 1'b1;
  logic [3:0] wait_q = 4'h0;
  initial drive = 8'ha5;
  initial rx = 8'h00;
  initial rx_n = 8'h00;
  assign line_a = out_mode ? rdy_q : dav_q;
  task automatic send(input logic [7:0] b);
    int i;
    for (i = 0; i < 50 && !line_b; i++)
      @(negedge clock);
    drive = b;
    @(negedge clock);
    dav_q = 1'b1;
    repeat (slow ? 4 : 2) @(negedge clock);
    dav_q = 1'b0;
    @(negedge clock);
    // Hold time over: released lines no longer show the byte
    drive = ~b;
  endtask
  always @(negedge clock) begin
    if (out_mode && rdy_q && line_b) begin
      rx <= pins;
      rx_n <= rx_n + 8'h01;
      rdy_q <= 1'b0;
      wait_q <= slow ? 4'hc : 4'h7;
    end else if (!rdy_q) begin
      if (wait_q == 4'h0)
        rdy_q <= 1'b1;
      else
        wait_q <= wait_q - 4'h1;
    end
  end
endmodule // hs_partner

// >>> tb/nibble_io_port_with_handshake_bench.sv
// Self-checking bench for the four-port I/O block.
// Assumes the design, its package and the handshake partner model.
`timescale 1ns/1ps
module nibble_io_port_with_handshake_bench;
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic out_mode = 0, slow = 0, line_a;
  logic [7:0] reg_addr = 0, reg_wdata = 0, p2_ext = 0, reg_rdata;
  logic [3:0] expanded_register_bank = 0, port_three_in;
  logic [2:0] p3_ext = 0;
  logic [7:0] port_zero_in, port_zero_out, port_zero_oe, port_two_in;
  logic [7:0] port_two_out, port_two_oe, port_three_out, port_three_oe;
  logic [7:0] drive, rx, rx_n, p1_ext = 0, mem_addr = 0;
  logic [7:0] port_one_out, port_one_oe, mem_ad_in;
  int err_count = 0, check_count = 0, cyc = 0;
  // Pin levels: a driven bit shows the design, else the far side
  assign port_zero_in = (port_zero_oe & port_zero_out) |
    (~port_zero_oe & drive);
  assign port_two_in = (port_two_oe & port_two_out) | (~port_two_oe & p2_ext);
  assign port_three_in = {p3_ext[2], line_a, p3_ext[1:0]};
  io_ports i_io_ports (.clock, .rst_n, .reg_addr, .expanded_register_bank,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .port_zero_in, .port_zero_out,
    .port_zero_oe, .port_one_in(p1_ext), .port_one_out, .port_one_oe,
    .port_two_in, .port_two_out, .port_two_oe, .port_three_in,
    .port_three_out, .port_three_oe, .mem_addr_out(mem_addr),
    .mem_ad_out(8'h00), .mem_ad_oe(1'b0), .mem_ad_in);
  hs_partner i_hs_partner (.clock, .out_mode, .slow,
    .line_b(port_three_out[5]), .pins(port_zero_in), .line_a, .drive, .rx,
    .rx_n);
  always #2.5 clock = ~clock;
  // ==========================================================
  // Shared tasks
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out;
    end
  end
  task automatic cmp(input logic [7:0] got_v, input logic [7:0] exp_v);
    check_count++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("Error at %0t got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    // Let pin changes pass the synchroniser before the next read
    repeat (3) @(negedge clock);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    cmp(reg_rdata, e);
  endtask
  task automatic wait_rx(input logic [7:0] n);
    for (int i = 0; i < 40 && rx_n !== n; i++)
      @(negedge clock);
    cmp(rx_n, n);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rc(8'hf8, 8'h49);
    rc(8'hf6, 8'hff);
    rc(8'hf7, 8'h00);
    cmp(port_three_out, 8'hf0);
    cmp(port_zero_oe | port_two_oe, 8'h00);
    cmp(port_one_oe, 8'h00);
    cmp(port_three_oe, 8'hf0);
    $display("reset test done");
  endtask
  task automatic t_regs;
    expanded_register_bank = 4'h5;
    wr(8'hf6, 8'h0f);
    rc(8'hf6, 8'h0f);
    cmp(port_two_oe, 8'hf0);
    wr(8'h02, 8'h3c);
    cmp(port_two_out, 8'h00);
    rc(8'h02, 8'h00);
    rc(8'h40, 8'h00);
    expanded_register_bank = 4'h0;
    $display("register test done");
  endtask
  task automatic t_inout;
    p2_ext = 8'ha5;
    wr(8'hf6, 8'hff);
    wr(8'h02, 8'h3c);
    rc(8'h02, 8'ha5);
    wr(8'hf6, 8'h0f);
    cmp(port_two_out, 8'h3c);
    rc(8'h02, 8'h35);
    wr(8'hf7, 8'h01);
    cmp(port_two_oe, 8'hc0);
    rc(8'h02, 8'h25);
    wr(8'hf7, 8'h00);
    wr(8'hf6, 8'hff);
    p2_ext = 8'h00;
    repeat (3) @(negedge clock);
    p2_ext = 8'hff;
    p3_ext = 3'h5;
    rc(8'h02, 8'h00);
    rc(8'h02, 8'hff);
    rc(8'h03, 8'hf9);
    $display("in-out test done");
  endtask
  task automatic t_nibbles;
    wr(8'hf8, 8'h48);
    cmp(port_zero_oe, 8'h0f);
    wr(8'h00, 8'hc3);
    rc(8'h00, 8'ha3);
    expanded_register_bank = 4'h1;
    wr(8'h00, 8'h00);
    cmp(port_zero_out, 8'hc3);
    expanded_register_bank = 4'h0;
    wr(8'hf8, 8'h09);
    cmp(port_zero_oe, 8'hf0);
    rc(8'h00, 8'hc5);
    $display("nibble test done");
  endtask
  task automatic t_wide;
    p1_ext = 8'h6c;
    mem_addr = 8'hd2;
    wr(8'hf8, 8'h80);
    cmp(port_zero_out, 8'hd3);
    cmp(port_zero_oe, 8'hff);
    wr(8'h01, 8'h5a);
    cmp(port_one_out, 8'h5a);
    cmp(port_one_oe, 8'hff);
    rc(8'h01, 8'h6c);
    cmp(mem_ad_in, 8'h6c);
    wr(8'hf8, 8'h24);
    cmp(port_zero_oe, 8'h3c);
    cmp(port_one_oe, 8'ha5);
    rc(8'h00, 8'h81);
    wr(8'hf8, 8'h10);
    cmp(port_one_oe, 8'h00);
    $display("wide port test done");
  endtask
  task automatic t_hs_in;
    wr(8'hf8, 8'h49);
    wr(8'hf7, 8'h04);
    cmp(port_three_out & 8'h20, 8'h20);
    i_hs_partner.send(8'h5a);
    repeat (3) @(negedge clock);
    cmp(port_three_out & 8'h20, 8'h00);
    rc(8'h00, 8'h5a);
    @(negedge clock);
    cmp(port_three_out & 8'h20, 8'h20);
    wr(8'hf8, 8'h48);
    i_hs_partner.send(8'h96);
    repeat (3) @(negedge clock);
    rc(8'h00, 8'h93);
    $display("input handshake test done");
  endtask
  task automatic t_hs_out;
    wr(8'hf8, 8'h08);
    out_mode = 1'b1;
    wr(8'h00, 8'he7);
    wait_rx(8'h01);
    cmp(rx, 8'he7);
    slow = 1'b1;
    wr(8'h00, 8'h18);
    wait_rx(8'h02);
    cmp(rx, 8'h18);
    repeat (10) @(negedge clock);
    cmp(port_three_out & 8'h20, 8'h00);
    $display("output handshake test done");
  endtask
  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_inout;
    t_nibbles;
    t_wide;
    t_hs_in;
    t_hs_out;
    close_out;
  end
endmodule // nibble_io_port_with_handshake_bench
